// >>> slave_port_map.vh
// Contract
// - Device is bus timing slave, never clocks.
// - Frame rate stays 8kHz in both modes.
// - All timing derived from bus bit clock; the code times bus deactivation in system clock cycles.
// - Data lines high-impedance unless actively transmitting.
// - Data lines driven open-drain only.
// - Receive downstream, transmit upstream.
// - Terminal mode intercomm slots reverse line directions.
// - Bus address from three slot strap pins.
// - Control bit 3 loops received data back.
// - Ignore unused bits; send unused bits as one.
// - Reset pin low clears every register.
// - Reset command over control channel resets fully; the code leaves the input synchronisers and the clock edge history as they are.
// - All control through the serial interface; the code writes the control register from the register port instead.
// - Terminal frame: three channels, 96 bits.
// - Line-card frame: eight channels, 256 bits.
// - Mode pin low terminal, high line-card.
// - Monitor answers only after matching address byte.
`ifndef SLAVE_PORT_MAP_VH
`define SLAVE_PORT_MAP_VH

// Register byte addresses
`define ADDR_CTRL      8'h00
`define ADDR_TX_WORD   8'h04
`define ADDR_RX_WORD   8'h08
`define ADDR_STATUS    8'h0c

// Control register fields
`define CTRL_LOOP_BIT  3
`define CTRL_REV_BIT   4
`define CTRL_WIDTH     8
`define CTRL_RESET     8'h00

// Frame geometry
`define TE_FRAME_BITS  9'h060
`define LC_FRAME_BITS  9'h100
`define TE_CHAN_BASE   9'h020
`define CHAN_BITS      9'h020
`define CHAN_LAST      5'h1f
`define MON_LAST       5'h17
`define MON_BYTE_IDX   2'h2
`define IC_BYTES       2'h2

// Monitor channel bytes
`define MON_ADDR_TAG   1'b1
`define MON_ADDR_LOW   3'h0
`define MON_RESET_CMD  8'h0e

// Bus idle time before the port counts as deactivated
`define IDLE_CYCLES    16'h0100

`endif

// >>> tdm_serial_bus_slave_port.v
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "slave_port_map.vh"

module tdm_serial_bus_slave_port
#(
  parameter IDLE_CYC = `IDLE_CYCLES
)
(
  // System
  input  wire        clk,
  input  wire        resetn,
  // Serial bus, all timing supplied from outside
  input  wire        frame_sync,
  input  wire        bit_clock,
  input  wire        dd_in,
  output wire        dd_out,
  output wire        dd_oen,
  input  wire        du_in,
  output wire        du_out,
  output wire        du_oen,
  // Straps
  input  wire        mode_select_pin,
  input  wire        slot_addr_bit0,
  input  wire        slot_addr_bit1,
  input  wire        slot_addr_bit2,
  input  wire        device_select,
  // Register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output wire [31:0] rdata
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers

  wire [8:0]  async_in;
  reg  [8:0]  sync1_q;
  reg  [8:0]  sync2_q;

  assign async_in = {device_select, slot_addr_bit2, slot_addr_bit1,
                     slot_addr_bit0, mode_select_pin, du_in, dd_in,
                     frame_sync, bit_clock};

  // First stage is read only by the second stage
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  wire        bclk_s;
  wire        fs_s;
  wire        dd_s;
  wire        du_s;
  wire        lc_mode;
  wire [2:0]  slot_s;
  wire        ds_s;

  assign bclk_s  = sync2_q[0];
  assign fs_s    = sync2_q[1];
  assign dd_s    = sync2_q[2];
  assign du_s    = sync2_q[3];
  assign lc_mode = sync2_q[4];
  assign slot_s  = sync2_q[7:5];
  assign ds_s    = sync2_q[8];

////////////////////////////////////////////////////////////////////////////////
// Bit timing, taken only from the bus clock

  reg         bclk_prev_q;
  reg         fs_at_q;
  reg         half_q;
  reg  [8:0]  bit_q;
  reg         live_q;
  reg  [15:0] idle_q;
  reg         srst_q;

  wire        bclk_rise;
  wire        frame_start;
  wire        drive_ev;
  wire        samp_ev;
  wire [8:0]  frame_bits;
  wire [8:0]  bit_next;
  wire [8:0]  drive_pos;

  // Edges found by sampling; no clock is ever generated here
  assign bclk_rise   = bclk_s & ~bclk_prev_q;
  assign frame_start = bclk_rise & fs_s & ~fs_at_q;
  assign frame_bits  = lc_mode ? `LC_FRAME_BITS : `TE_FRAME_BITS;
  assign bit_next    = (bit_q == frame_bits) ? bit_q : bit_q + 9'h001;
  assign drive_ev    = bclk_rise & (frame_start | half_q);
  assign samp_ev     = bclk_rise & ~frame_start & ~half_q;
  assign drive_pos   = frame_start ? 9'h000 : bit_next;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bclk_prev_q <= 1'b0;
      fs_at_q     <= 1'b0;
      half_q      <= 1'b0;
      bit_q       <= 9'h000;
      live_q      <= 1'b0;
      idle_q      <= 16'h0000;
    end
    else if (srst_q)
    begin
      bclk_prev_q <= bclk_s;
      fs_at_q     <= 1'b0;
      half_q      <= 1'b0;
      bit_q       <= 9'h000;
      live_q      <= 1'b0;
      idle_q      <= 16'h0000;
    end
    else
    begin
      bclk_prev_q <= bclk_s;
      if (bclk_rise)
      begin
        fs_at_q <= fs_s;
        idle_q  <= 16'h0000;
        if (frame_start)
        begin
          half_q <= 1'b0;
          bit_q  <= 9'h000;
          live_q <= 1'b1;
        end
        else
        begin
          half_q <= ~half_q;
          if (half_q)
            bit_q <= bit_next;
        end
      end
      // A clock held low for long means the bus is deactivated
      else if (idle_q == IDLE_CYC[15:0])
        live_q <= 1'b0;
      else
        idle_q <= idle_q + 16'h0001;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Channel position decode

  reg  [7:0]  ctrl_q;
  reg  [31:0] tx_q;
  reg  [31:0] rx_q;
  reg  [31:0] rx_sh_q;
  reg         addressed_q;

  wire [8:0]  chan_base;
  wire        loop_en;
  wire        rev_en;

  // Terminal mode uses its fixed channel, line-card mode the slot
  assign chan_base = lc_mode ? {1'b0, slot_s, 5'h00} : `TE_CHAN_BASE;
  assign loop_en   = ctrl_q[`CTRL_LOOP_BIT];
  assign rev_en    = ctrl_q[`CTRL_REV_BIT] & ~lc_mode;

  wire [8:0]  d_off9;
  wire        d_in_ch;
  wire [4:0]  d_off;
  wire        d_ic;
  wire        d_mon;
  wire [31:0] d_src;
  wire        d_bit;
  wire        du_bit;
  wire        dd_bit;
  wire        live_now;

  // A frame's first bit is driven in the same cycle that starts it,
  // otherwise slot zero would lose its first bit
  assign live_now = live_q | frame_start;
  assign d_off9  = drive_pos - chan_base;
  assign d_in_ch = (drive_pos >= chan_base) & (d_off9 < `CHAN_BITS) &
                   (drive_pos < frame_bits);
  assign d_off   = d_off9[4:0];
  assign d_ic    = rev_en & (d_off[4:3] < `IC_BYTES);
  assign d_mon   = (d_off[4:3] == `MON_BYTE_IDX);
  assign d_src   = loop_en ? rx_q : tx_q;
  // Monitor byte stays silent until this device is addressed
  assign d_bit   = (d_mon & ~addressed_q) | d_src[`CHAN_LAST - d_off];
  assign du_bit  = ~(live_now & d_in_ch & ~d_ic) | d_bit;
  assign dd_bit  = ~(live_now & d_in_ch & d_ic) | d_bit;

  wire [8:0]  s_off9;
  wire        s_in_ch;
  wire [4:0]  s_off;
  wire        s_bit;
  wire [7:0]  mon_byte;
  wire [7:0]  my_addr;

  assign s_off9   = bit_q - chan_base;
  assign s_in_ch  = (bit_q >= chan_base) & (s_off9 < `CHAN_BITS) &
                    (bit_q < frame_bits);
  assign s_off    = s_off9[4:0];
  // Reversed intercomm bytes arrive on the upstream line
  assign s_bit    = (rev_en & (s_off[4:3] < `IC_BYTES)) ? du_s : dd_s;
  assign mon_byte = {rx_sh_q[15:9], s_bit};
  assign my_addr  = {`MON_ADDR_TAG, slot_s, ds_s, `MON_ADDR_LOW};

////////////////////////////////////////////////////////////////////////////////
// Receive shift and monitor address match

  wire        samp_ch;
  wire        mon_done;

  // Sampling waits for the second clock of each bit
  assign samp_ch  = samp_ev & live_q & s_in_ch;
  assign mon_done = samp_ch & (s_off == `MON_LAST);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_sh_q     <= 32'h00000000;
      rx_q        <= 32'h00000000;
      addressed_q <= 1'b0;
    end
    else if (srst_q)
    begin
      rx_sh_q     <= 32'h00000000;
      rx_q        <= 32'h00000000;
      addressed_q <= 1'b0;
    end
    else
    begin
      if (samp_ch)
        rx_sh_q[`CHAN_LAST - s_off] <= s_bit;
      if (samp_ch & (s_off == `CHAN_LAST))
        rx_q <= {rx_sh_q[31:1], s_bit};
      // An address byte for another device drops the selection
      if (mon_done & mon_byte[7])
        addressed_q <= (mon_byte == my_addr);
    end
  end

  // Command reset lasts one cycle and clears what the pin clears, except the input synchronisers and the clock edge history
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      srst_q <= 1'b0;
    else
      srst_q <= ~srst_q & mon_done & addressed_q &
                (mon_byte == `MON_RESET_CMD);
  end

////////////////////////////////////////////////////////////////////////////////
// Open-drain pin drive

  reg         dd_oen_q;
  reg         du_oen_q;
  reg         pin_low_q;

  // Only a zero is driven; a one is left to the pull-up
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dd_oen_q  <= 1'b1;
      du_oen_q  <= 1'b1;
      pin_low_q <= 1'b0;
    end
    else if (srst_q | ~live_now)
    begin
      dd_oen_q  <= 1'b1;
      du_oen_q  <= 1'b1;
      pin_low_q <= 1'b0;
    end
    else
    begin
      pin_low_q <= 1'b0;
      if (drive_ev)
      begin
        du_oen_q <= du_bit;
        dd_oen_q <= dd_bit;
      end
    end
  end

  assign dd_out = pin_low_q;
  assign du_out = pin_low_q;
  assign dd_oen = dd_oen_q;
  assign du_oen = du_oen_q;

////////////////////////////////////////////////////////////////////////////////
// Register port

  reg  [31:0] rdata_q;
  reg  [31:0] rd_mux;

  // Read data is zero outside the cycle after a read

  always @*
  begin
    case (addr)
      `ADDR_CTRL:    rd_mux = {24'h000000, ctrl_q};
      `ADDR_TX_WORD: rd_mux = tx_q;
      `ADDR_RX_WORD: rd_mux = rx_q;
      `ADDR_STATUS:  rd_mux = {24'h000000, ds_s, slot_s, lc_mode,
                               addressed_q, half_q, live_q};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  // Registers are controlled only from this port and the bus itself
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q  <= `CTRL_RESET;
      tx_q    <= 32'h00000000;
      rdata_q <= 32'h00000000;
    end
    else if (srst_q)
    begin
      ctrl_q  <= `CTRL_RESET;
      tx_q    <= 32'h00000000;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rdata_q <= rd ? rd_mux : 32'h00000000;
      if (wr & (addr == `ADDR_CTRL))
        ctrl_q <= wdata[`CTRL_WIDTH-1:0];
      if (wr & (addr == `ADDR_TX_WORD))
        tx_q <= wdata;
    end
  end

  assign rdata = rdata_q;

endmodule // tdm_serial_bus_slave_port

// >>> tdm_serial_bus_slave_port_assertions.sv
`timescale 1ns/10ps

module tdm_serial_bus_slave_port_checker
#(
  parameter IDLE_CYC = 256
)
(
  // System
  input wire        clk,
  input wire        resetn,
  // Bus
  input wire        bit_clock,
  input wire        mode_select_pin,
  input wire        dd_out,
  input wire        dd_oen,
  input wire        du_out,
  input wire        du_oen,
  // Registers
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata
);
  reg       bc_q;
  reg [8:0] rise_cnt;
  reg [8:0] still_cnt;

  // Raw pin is seen here before the design's synchronisers
  always @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      bc_q      <= 1'b0;
      rise_cnt  <= 9'h1ff;
      still_cnt <= 9'h000;
    end
    else
    begin
      bc_q      <= bit_clock;
      rise_cnt  <= (bit_clock && !bc_q) ? 9'h000 :
                   rise_cnt + {8'h00, rise_cnt != 9'h1ff};
      still_cnt <= (bit_clock != bc_q) ? 9'h000 :
                   still_cnt + {8'h00, still_cnt != 9'h1ff};
    end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////
  property p_open_drain;
    dd_out == 1'b0 && du_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line driven high");
  property p_reset_quiet;
    $rose(resetn) |-> dd_oen && du_oen && rdata == 32'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("not quiet after reset");
  property p_rd_only;
    !rd |=> rdata == 32'h0;
  endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("read data without read");
  property p_unmapped;
    rd && (addr > 8'h0c || addr[1:0] != 2'h0) |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_ctrl_back;
    wr && addr == 8'h00 ##1 !wr ##1 rd && addr == 8'h00
      |=> rdata == ($past(wdata, 3) & 32'hff);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back)
    else $error("control readback wrong");
  property p_idle_release;
    still_cnt > IDLE_CYC + 8 |-> dd_oen && du_oen;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("line held on stopped clock");
  property p_du_after_rise;
    $fell(du_oen) |-> rise_cnt <= 9'h008;
  endproperty
  a_du_after_rise: assert property (p_du_after_rise)
    else $error("upstream drive off clock");
  property p_dd_after_rise;
    $fell(dd_oen) |-> rise_cnt <= 9'h008;
  endproperty
  a_dd_after_rise: assert property (p_dd_after_rise)
    else $error("downstream drive off clock");
  property p_bit_hold;
    $fell(du_oen) |=> !du_oen [*8];
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("bit not held");
  property p_lc_no_dd;
    mode_select_pin |-> dd_oen;
  endproperty
  a_lc_no_dd: assert property (p_lc_no_dd)
    else $error("downstream driven in line-card");
endmodule // tdm_serial_bus_slave_port_checker

bind tdm_serial_bus_slave_port tdm_serial_bus_slave_port_checker
  #(.IDLE_CYC(IDLE_CYC)) chk_inst
(
  .clk(clk), .resetn(resetn), .bit_clock(bit_clock),
  .mode_select_pin(mode_select_pin), .dd_out(dd_out),
  .dd_oen(dd_oen), .du_out(du_out), .du_oen(du_oen), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
);

// >>> bus_upstream_model.sv
`timescale 1ns/10ps

module bus_upstream_model
(
  // Bus
  output logic bit_clock,
  output logic frame_sync,
  output logic dd_pull_n,
  output logic du_pull_n,
  input  wire  dd,
  input  wire  du
);
  // Clock stands low between frames
  initial
  begin
    bit_clock  = 1'b0;
    frame_sync = 1'b0;
    dd_pull_n  = 1'b1;
    du_pull_n  = 1'b1;
  end

  ////////////////////////////////////////
  // Bit k at v[255-k] downstream, u[255-k] upstream; drive after first
  // rise, sample on second
  task automatic run_frame(input logic [255:0] v, u, input int n,
                           output logic [255:0] seen, dseen);
    seen  = '1;
    dseen = '1;
    // Off the system clock edge, so the design never races the model
    #81 frame_sync = 1'b1;
    for (int r = 0; r < 2 * n; r++)
    begin
      bit_clock = 1'b1;
      if (r[0])
      begin
        seen[255 - r / 2]  = du;
        dseen[255 - r / 2] = dd;
      end
      #80 bit_clock = 1'b0;
      if (r == 1)
        frame_sync = 1'b0;
      if (!r[0])
      begin
        dd_pull_n = v[255 - r / 2];
        du_pull_n = u[255 - r / 2];
      end
      #80;
    end
    dd_pull_n = 1'b1;
    du_pull_n = 1'b1;
  endtask
endmodule // bus_upstream_model

// >>> test_tdm_serial_bus_slave_port.sv
`timescale 1ns/10ps

module test_tdm_serial_bus_slave_port;
  logic         clk, resetn, mode_select_pin, wr, rd;
  logic [2:0]   slot;
  logic         ds;
  logic [7:0]   addr;
  logic [31:0]  wdata;
  logic [255:0] du_seen, dd_seen, du_drive;
  wire  [31:0]  rdata;
  wire          bit_clock, frame_sync, dd_pull_n, du_pull_n;
  wire          dd_out, dd_oen, du_out, du_oen;
  // Pull-ups: a released line reads one
  wire          dd_in = (dd_oen | dd_out) & dd_pull_n;
  wire          du_in = (du_oen | du_out) & du_pull_n;
  int           fails, n_tests;

  // Short idle span lets the bus deactivate within the 100 cycles that follow each frame
  tdm_serial_bus_slave_port #(.IDLE_CYC(64)) tdm_serial_bus_slave_port_inst
  (
    .clk(clk), .resetn(resetn), .frame_sync(frame_sync),
    .bit_clock(bit_clock), .dd_in(dd_in), .dd_out(dd_out),
    .dd_oen(dd_oen), .du_in(du_in), .du_out(du_out), .du_oen(du_oen),
    .mode_select_pin(mode_select_pin), .slot_addr_bit0(slot[0]),
    .slot_addr_bit1(slot[1]), .slot_addr_bit2(slot[2]),
    .device_select(ds), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata)
  );
  bus_upstream_model bus_upstream_model_inst
  (
    .bit_clock(bit_clock), .frame_sync(frame_sync),
    .dd_pull_n(dd_pull_n), .du_pull_n(du_pull_n), .dd(dd_in),
    .du(du_in)
  );

  ////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string s, input logic [7:0] a,
                        input logic [31:0] exp, m = 32'hffffffff);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(s, rdata & m, exp);
  endtask
  task automatic frame(input logic [255:0] v, input int n);
    bus_upstream_model_inst.run_frame(v, du_drive, n, du_seen, dd_seen);
    repeat (100) @(posedge clk);
  endtask
  task automatic t_reset;
    rd_chk("ctrl", 8'h00, 32'h0);
    rd_chk("tx", 8'h04, 32'h0);
    wr_reg(8'h0c, 32'hff);
    rd_chk("status", 8'h0c, 32'hd0);
    rd_chk("unmapped", 8'h10, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_term;
    wr_reg(8'h04, 32'h5a3cff81);
    frame({32'h0, 32'h1234ff78, 192'h0}, 96);
    chk("du ch0", du_seen[255 -: 32], 32'hffffffff);
    chk("du own", du_seen[223 -: 32], 32'h5a3cff81);
    chk("du ch2", du_seen[191 -: 32], 32'hffffffff);
    rd_chk("rx", 8'h08, 32'h1234ff78);
    $display("t_term done");
  endtask
  task automatic t_loop;
    wr_reg(8'h00, 32'h08);
    rd_chk("ctrl", 8'h00, 32'h08);
    frame({32'h0, 32'hcafeffee, 192'h0}, 96);
    chk("du loop", du_seen[223 -: 32], 32'h1234ff78);
    rd_chk("rx", 8'h08, 32'hcafeffee);
    rd_chk("idle", 8'h0c, 32'hd0, 32'hfd);
    wr_reg(8'h00, 32'h80);
    $display("t_loop done");
  endtask
  task automatic t_rev;
    wr_reg(8'h00, 32'h10);
    wr_reg(8'h04, 32'ha55aff3c);
    du_drive = '1;
    du_drive[223 -: 16] = 16'h6996;
    frame({32'h0, 32'hffffffc3, 192'h0}, 96);
    du_drive = '1;
    chk("dd ic", dd_seen[223 -: 32], 32'ha55affc3);
    chk("du rev", du_seen[223 -: 32], 32'h6996ff3c);
    rd_chk("rev rx", 8'h08, 32'h6996ffc3);
    $display("t_rev done");
  endtask
  task automatic t_lc;
    @(posedge clk) mode_select_pin <= 1'b1;
    wr_reg(8'h04, 32'h0badff0d);
    frame({160'h0, 32'h0000d800, 64'h0}, 256);
    chk("lc own", du_seen[95 -: 32], 32'h0badff0d);
    chk("lc ch4", du_seen[127 -: 32], 32'hffffffff);
    rd_chk("addressed", 8'h0c, 32'hdc, 32'hfd);
    rd_chk("lc rx", 8'h08, 32'h0000d800);
    frame({160'h0, 32'h00000e00, 64'h0}, 256);
    rd_chk("ctrl", 8'h00, 32'h0);
    rd_chk("tx", 8'h04, 32'h0);
    rd_chk("status", 8'h0c, 32'hd8, 32'hfd);
    $display("t_lc done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    resetn          = 1'b0;
    mode_select_pin = 1'b0;
    slot            = 3'h5;
    ds              = 1'b1;
    wr              = 1'b0;
    rd              = 1'b0;
    addr            = 8'h00;
    wdata           = 32'h0;
    du_drive        = '1;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_term;
    t_loop;
    t_rev;
    t_lc;
    wrap_up;
  end
  // Five frames take about 260 us
  initial
  begin
    #400000;
    fails++;
    wrap_up;
  end
endmodule // test_tdm_serial_bus_slave_port
